// *** shared/smu_defines.svh ***
`ifndef SMU_DEFINES_SVH
`define SMU_DEFINES_SVH

// ============================================================
// register offsets (byte addresses)
`define SMU_OFS_TASK_BEGIN 12'h010
`define SMU_OFS_TASK_HALT 12'h014
`define SMU_OFS_TASK_PAUSE 12'h01C
`define SMU_OFS_TASK_CONT 12'h020
`define SMU_OFS_SUB_BEGIN 12'h090
`define SMU_OFS_SUB_HALT 12'h094
`define SMU_OFS_SUB_PAUSE 12'h09C
`define SMU_OFS_SUB_CONT 12'h0A0
`define SMU_OFS_EVT_HALTED 12'h104
`define SMU_OFS_EVT_RX_DONE 12'h110
`define SMU_OFS_EVT_BOTH_DONE 12'h118
`define SMU_OFS_EVT_TX_DONE 12'h120
`define SMU_OFS_EVT_BEGUN 12'h14C
`define SMU_OFS_PUB_HALTED 12'h184
`define SMU_OFS_PUB_RX_DONE 12'h190
`define SMU_OFS_PUB_BOTH_DONE 12'h198
`define SMU_OFS_PUB_TX_DONE 12'h1A0
`define SMU_OFS_PUB_BEGUN 12'h1CC
`define SMU_OFS_EVENT_TASK_SHORTCUTS 12'h200
`define SMU_OFS_IRQ_SET 12'h304
`define SMU_OFS_IRQ_CLR 12'h308
`define SMU_OFS_ENABLE 12'h500
`define SMU_OFS_PSEL_CLOCK 12'h508
`define SMU_OFS_PSEL_DOUT 12'h50C
`define SMU_OFS_PSEL_DIN 12'h510
`define SMU_OFS_BIT_RATE 12'h524
`define SMU_OFS_RX_PTR 12'h534
`define SMU_OFS_RX_LEN 12'h538
`define SMU_OFS_RX_COUNT 12'h53C
`define SMU_OFS_RX_LIST 12'h540
`define SMU_OFS_TX_PTR 12'h544
`define SMU_OFS_TX_LEN 12'h548
`define SMU_OFS_TX_COUNT 12'h54C
`define SMU_OFS_TX_LIST 12'h550
`define SMU_OFS_CONFIG 12'h554
`define SMU_OFS_OVERREAD 12'h5C0

// ============================================================
// field positions and values
`define SMU_CHAN_EN_BIT 31
`define SMU_PSEL_CONNECT_BIT 31
`define SMU_ENABLE_ON 4'h7
`define SMU_CFG_ORDER_BIT 0
`define SMU_CFG_CPHA_BIT 1
`define SMU_CFG_CPOL_BIT 2
`define SMU_LAST_EDGE 4'hF

// ============================================================
// reset values
`define SMU_PSEL_RESET 32'hFFFFFFFF
`define SMU_RATE_RESET 8'h04

`endif

// *** shared/smu_pkg.sv ***
package smu_pkg;

	// ============================================================
	// engine states
	typedef enum logic [2:0] {
		SMU_IDLE = 3'b000,
		SMU_LOAD = 3'b001,
		SMU_FETCH = 3'b010,
		SMU_GRAB = 3'b011,
		SMU_SHIFT = 3'b100,
		SMU_PAUSED = 3'b101
	} smu_state_t;

	// event indices
	typedef enum logic [2:0] {
		SMU_EV_HALTED = 3'b000,
		SMU_EV_RX = 3'b001,
		SMU_EV_BOTH = 3'b010,
		SMU_EV_TX = 3'b011,
		SMU_EV_BEGUN = 3'b100
	} smu_event_t;

	// ============================================================
	// carriers
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} smu_bus_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
	} smu_mem_req_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic dout;
		logic dout_oe;
	} smu_pins_t;

endpackage

// *** rtl/smu_master.sv ***
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "smu_defines.svh"
module smu_master
	import smu_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int CHAN_N = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire smu_bus_req_t bus,
	output logic [31:0] bus_rdata,
	// event channels
	input wire logic [CHAN_N-1:0] chan_trig,
	output logic [CHAN_N-1:0] chan_pub,
	// buffer memory port, read data one cycle after rd
	output smu_mem_req_t mem,
	input wire logic [7:0] mem_rdata,
	// serial pins
	output smu_pins_t pins,
	input wire logic din
);

	// ============================================================
	// state
	typedef struct packed {
		smu_state_t st;
		logic [3:0] enable;
		logic [3:0][4:0] sub;
		logic [4:0][4:0] pub;
		logic [4:0] evt;
		logic [4:0] irq_mask;
		logic short_en;
		logic [31:0] psel_sck;
		logic [31:0] psel_dout;
		logic [31:0] psel_din;
		logic [7:0] rate;
		logic [2:0] cfg;
		logic [7:0] overread_char;
		logic [1:0] rx_list;
		logic [1:0] tx_list;
		logic [31:0] rx_ptr_sh;
		logic [31:0] tx_ptr_sh;
		logic [CNT_W-1:0] rx_len_sh;
		logic [CNT_W-1:0] tx_len_sh;
		logic [31:0] rx_ptr;
		logic [31:0] tx_ptr;
		logic [CNT_W-1:0] rx_len;
		logic [CNT_W-1:0] tx_len;
		logic [CNT_W-1:0] rx_cnt;
		logic [CNT_W-1:0] tx_cnt;
		logic tx_seen;
		logic rx_seen;
		logic halt_pend;
		logic pause_pend;
		logic restart;
		logic [7:0] div;
		logic [3:0] edge_n;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [31:0] rdata;
		smu_mem_req_t mem;
		smu_pins_t pins;
		logic [CHAN_N-1:0] pub_out;
		logic [1:0] din_sync;
	} smu_regs_t;

	localparam logic [3:0][11:0] TASK_OFS = {`SMU_OFS_TASK_CONT, `SMU_OFS_TASK_PAUSE,
		`SMU_OFS_TASK_HALT, `SMU_OFS_TASK_BEGIN};
	localparam logic [3:0][11:0] SUB_OFS = {`SMU_OFS_SUB_CONT, `SMU_OFS_SUB_PAUSE,
		`SMU_OFS_SUB_HALT, `SMU_OFS_SUB_BEGIN};
	localparam logic [4:0][11:0] EVT_OFS = {`SMU_OFS_EVT_BEGUN, `SMU_OFS_EVT_TX_DONE,
		`SMU_OFS_EVT_BOTH_DONE, `SMU_OFS_EVT_RX_DONE, `SMU_OFS_EVT_HALTED};
	localparam logic [4:0][11:0] PUB_OFS = {`SMU_OFS_PUB_BEGUN, `SMU_OFS_PUB_TX_DONE,
		`SMU_OFS_PUB_BOTH_DONE, `SMU_OFS_PUB_RX_DONE, `SMU_OFS_PUB_HALTED};

	smu_regs_t q;
	smu_regs_t d;
	logic [3:0] task_go;

	// ============================================================
	// task triggers: register write or subscribed channel
	genvar gi;
	for (gi = 0; gi < 4; gi++) begin : g_task
		assign task_go[gi] = (bus.wr && bus.addr == TASK_OFS[gi] && bus.wdata[0]) ||
			(q.sub[gi][4] && chan_trig[q.sub[gi][3:0]]);
	end

	// next output bit, order chosen by config
	function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
		out_bit = lsb_first ? sh[0] : sh[7];
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb_first);
		shift_out = lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
	endfunction

	// ============================================================
	// next-state logic
	always_comb begin
		logic [4:0] ev;
		logic on;
		logic lsb;
		logic cpha;
		logic cpol;
		logic tick;
		logic lead;
		logic do_halt;
		logic done;
		logic load_ok;
		logic [7:0] half;
		logic [7:0] byte_in;
		logic [7:0] rx_new;
		ev = '0;
		d = q;
		do_halt = 1'b0;
		load_ok = 1'b0;
		byte_in = 8'h00;
		on = (q.enable == `SMU_ENABLE_ON);
		lsb = q.cfg[`SMU_CFG_ORDER_BIT];
		cpha = q.cfg[`SMU_CFG_CPHA_BIT];
		cpol = q.cfg[`SMU_CFG_CPOL_BIT];
		half = (q.rate == 8'h00) ? 8'h01 : q.rate;
		tick = (q.div >= half - 8'h01);
		lead = ~q.edge_n[0];
		rx_new = lsb ? {q.din_sync[1], q.rx_sh[7:1]} : {q.rx_sh[6:0], q.din_sync[1]};
		done = (q.tx_cnt >= q.tx_len) && (q.rx_cnt >= q.rx_len);
		d.din_sync = {q.din_sync[0], din};
		d.mem.rd = 1'b0;
		d.mem.wr = 1'b0;
		d.rdata = 32'h00000000;
		d.restart = 1'b0;

		// register writes
		if (bus.wr) begin
			case (bus.addr)
				`SMU_OFS_EVENT_TASK_SHORTCUTS: d.short_en = bus.wdata[0];
				`SMU_OFS_IRQ_SET: d.irq_mask = q.irq_mask | bus.wdata[4:0];
				`SMU_OFS_IRQ_CLR: d.irq_mask = q.irq_mask & ~bus.wdata[4:0];
				`SMU_OFS_ENABLE: d.enable = bus.wdata[3:0];
				`SMU_OFS_PSEL_CLOCK: d.psel_sck = bus.wdata;
				`SMU_OFS_PSEL_DOUT: d.psel_dout = bus.wdata;
				`SMU_OFS_PSEL_DIN: d.psel_din = bus.wdata;
				`SMU_OFS_BIT_RATE: d.rate = bus.wdata[7:0];
				`SMU_OFS_RX_PTR: d.rx_ptr_sh = bus.wdata;
				`SMU_OFS_RX_LEN: d.rx_len_sh = bus.wdata[CNT_W-1:0];
				`SMU_OFS_RX_LIST: d.rx_list = bus.wdata[1:0];
				`SMU_OFS_TX_PTR: d.tx_ptr_sh = bus.wdata;
				`SMU_OFS_TX_LEN: d.tx_len_sh = bus.wdata[CNT_W-1:0];
				`SMU_OFS_TX_LIST: d.tx_list = bus.wdata[1:0];
				`SMU_OFS_CONFIG: d.cfg = bus.wdata[2:0];
				`SMU_OFS_OVERREAD: d.overread_char = bus.wdata[7:0];
				default: ;
			endcase
			for (int i = 0; i < 4; i++) begin
				if (bus.addr == SUB_OFS[i]) begin
					d.sub[i] = {bus.wdata[`SMU_CHAN_EN_BIT], bus.wdata[3:0]};
				end
			end
			for (int i = 0; i < 5; i++) begin
				if (bus.addr == PUB_OFS[i]) begin
					d.pub[i] = {bus.wdata[`SMU_CHAN_EN_BIT], bus.wdata[3:0]};
				end
				if (bus.addr == EVT_OFS[i]) begin
					d.evt[i] = bus.wdata[0];
				end
			end
		end

		// register reads, data stands in the following cycle
		if (bus.rd) begin
			case (bus.addr)
				`SMU_OFS_EVENT_TASK_SHORTCUTS: d.rdata = {31'h0, q.short_en};
				`SMU_OFS_IRQ_SET, `SMU_OFS_IRQ_CLR: d.rdata = {27'h0, q.irq_mask};
				`SMU_OFS_ENABLE: d.rdata = {28'h0, q.enable};
				`SMU_OFS_PSEL_CLOCK: d.rdata = q.psel_sck;
				`SMU_OFS_PSEL_DOUT: d.rdata = q.psel_dout;
				`SMU_OFS_PSEL_DIN: d.rdata = q.psel_din;
				`SMU_OFS_BIT_RATE: d.rdata = {24'h0, q.rate};
				`SMU_OFS_RX_PTR: d.rdata = q.rx_ptr_sh;
				`SMU_OFS_RX_LEN: d.rdata = 32'(q.rx_len_sh);
				`SMU_OFS_RX_COUNT: d.rdata = 32'(q.rx_cnt);
				`SMU_OFS_RX_LIST: d.rdata = {30'h0, q.rx_list};
				`SMU_OFS_TX_PTR: d.rdata = q.tx_ptr_sh;
				`SMU_OFS_TX_LEN: d.rdata = 32'(q.tx_len_sh);
				`SMU_OFS_TX_COUNT: d.rdata = 32'(q.tx_cnt);
				`SMU_OFS_TX_LIST: d.rdata = {30'h0, q.tx_list};
				`SMU_OFS_CONFIG: d.rdata = {29'h0, q.cfg};
				`SMU_OFS_OVERREAD: d.rdata = {24'h0, q.overread_char};
				default: d.rdata = 32'h00000000;
			endcase
			for (int i = 0; i < 4; i++) begin
				if (bus.addr == SUB_OFS[i]) begin
					d.rdata = {q.sub[i][4], 27'h0, q.sub[i][3:0]};
				end
			end
			for (int i = 0; i < 5; i++) begin
				if (bus.addr == PUB_OFS[i]) begin
					d.rdata = {q.pub[i][4], 27'h0, q.pub[i][3:0]};
				end
				if (bus.addr == EVT_OFS[i]) begin
					d.rdata = {31'h0, q.evt[i]};
				end
			end
		end

		// pending halt and pause requests
		if (task_go[1] && q.st != SMU_IDLE) begin
			d.halt_pend = 1'b1;
		end
		if (task_go[2] && q.st != SMU_IDLE) begin
			d.pause_pend = 1'b1;
		end
		if (task_go[3]) begin
			d.pause_pend = 1'b0;
		end

		// serial engine
		d.div = 8'h00;
		case (q.st)
			SMU_IDLE: begin
				d.pins.sck = cpol;
				if (task_go[1]) begin
					do_halt = 1'b1;
				end else if (task_go[0] || q.restart) begin
					// shadow copies go live, software may reload at once
					d.rx_ptr = q.rx_ptr_sh;
					d.tx_ptr = q.tx_ptr_sh;
					d.rx_len = q.rx_len_sh;
					d.tx_len = q.tx_len_sh;
					d.rx_cnt = '0;
					d.tx_cnt = '0;
					d.tx_seen = 1'b0;
					d.rx_seen = 1'b0;
					d.halt_pend = 1'b0;
					d.pause_pend = 1'b0;
					ev[SMU_EV_BEGUN] = 1'b1;
					d.st = SMU_LOAD;
				end
			end
			SMU_LOAD: begin
				// byte boundary: halt wins over finish, finish over pause
				if (q.halt_pend) begin
					do_halt = 1'b1;
				end else if (done) begin
					d.st = SMU_IDLE;
				end else if (q.pause_pend) begin
					d.st = SMU_PAUSED;
				end else if (q.tx_cnt < q.tx_len) begin
					d.mem.rd = 1'b1;
					d.mem.addr = q.tx_ptr + 32'(q.tx_cnt);
					d.st = SMU_FETCH;
				end else begin
					byte_in = q.overread_char;
					load_ok = 1'b1;
				end
			end
			SMU_FETCH: d.st = SMU_GRAB;
			SMU_GRAB: begin
				byte_in = mem_rdata;
				load_ok = 1'b1;
			end
			SMU_SHIFT: begin
				d.div = tick ? 8'h00 : q.div + 8'h01;
				if (tick) begin
					d.pins.sck = ~q.pins.sck;
					d.edge_n = q.edge_n + 4'h1;
					// phase 0 samples on leading edges, phase 1 on trailing
					if (lead != cpha) begin
						d.rx_sh = rx_new;
					end
					if ((lead && cpha) || (!lead && !cpha && q.edge_n != `SMU_LAST_EDGE)) begin
						d.pins.dout = out_bit(q.tx_sh, lsb);
						d.tx_sh = shift_out(q.tx_sh, lsb);
					end
					if (q.edge_n == `SMU_LAST_EDGE) begin
						if (q.tx_cnt < q.tx_len) begin
							d.tx_cnt = q.tx_cnt + CNT_W'(1);
						end
						// bytes beyond the receive length are dropped
						if (q.rx_cnt < q.rx_len) begin
							d.mem.wr = 1'b1;
							d.mem.addr = q.rx_ptr + 32'(q.rx_cnt);
							d.mem.wdata = cpha ? rx_new : q.rx_sh; // phase 0 already holds all eight bits
							d.rx_cnt = q.rx_cnt + CNT_W'(1);
						end
						d.st = SMU_LOAD;
					end
				end
			end
			SMU_PAUSED: begin
				d.pins.sck = cpol;
				if (q.halt_pend) begin
					do_halt = 1'b1;
				end else if (task_go[3]) begin
					d.st = SMU_LOAD;
				end
			end
			default: d.st = SMU_IDLE;
		endcase

		// prime the shifter with a fresh byte
		if (load_ok) begin
			d.edge_n = 4'h0;
			d.st = SMU_SHIFT;
			d.tx_sh = byte_in;
			if (!cpha) begin
				d.pins.dout = out_bit(byte_in, lsb);
				d.tx_sh = shift_out(byte_in, lsb);
			end
		end

		// done events follow the last memory access of each buffer
		if (q.st != SMU_IDLE && q.st != SMU_FETCH && q.st != SMU_GRAB) begin
			if (!q.tx_seen && q.tx_cnt >= q.tx_len) begin
				ev[SMU_EV_TX] = 1'b1;
				d.tx_seen = 1'b1;
			end
			if (!q.rx_seen && q.rx_cnt >= q.rx_len) begin
				ev[SMU_EV_RX] = 1'b1;
				d.rx_seen = 1'b1;
			end
		end

		// halting reports whatever done events are still owed
		if (do_halt) begin
			d.st = SMU_IDLE;
			d.halt_pend = 1'b0;
			d.pause_pend = 1'b0;
			d.pins.sck = cpol;
			ev[SMU_EV_HALTED] = 1'b1;
			if (!q.tx_seen) begin
				ev[SMU_EV_TX] = 1'b1;
			end
			if (!q.rx_seen) begin
				ev[SMU_EV_RX] = 1'b1;
			end
			d.tx_seen = 1'b1;
			d.rx_seen = 1'b1;
		end

		// both-done fires on the cycle the second flag rises
		if (d.tx_seen && d.rx_seen && !(q.tx_seen && q.rx_seen)) begin
			ev[SMU_EV_BOTH] = 1'b1;
			d.restart = q.short_en;
		end

		// disabled block: engine held idle, pins released
		if (!on) begin
			d.st = SMU_IDLE;
			d.halt_pend = 1'b0;
			d.pause_pend = 1'b0;
			d.restart = 1'b0;
			d.mem.rd = 1'b0;
			d.mem.wr = 1'b0;
			ev = '0;
		end
		d.pins.sck_oe = on && !q.psel_sck[`SMU_PSEL_CONNECT_BIT];
		d.pins.dout_oe = on && !q.psel_dout[`SMU_PSEL_CONNECT_BIT];

		// hardware set wins over a clearing write in the same cycle
		d.evt = d.evt | ev;
		d.pub_out = '0;
		for (int i = 0; i < 5; i++) begin
			if (ev[i] && q.pub[i][4]) begin
				d.pub_out[q.pub[i][3:0]] = 1'b1;
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
			q.st <= SMU_IDLE;
			q.psel_sck <= `SMU_PSEL_RESET;
			q.psel_dout <= `SMU_PSEL_RESET;
			q.psel_din <= `SMU_PSEL_RESET;
			q.rate <= `SMU_RATE_RESET;
			q.tx_seen <= 1'b1; // nothing owed until the first start
			q.rx_seen <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign bus_rdata = q.rdata;
	assign chan_pub = q.pub_out;
	assign mem = q.mem;
	assign pins = q.pins;

endmodule

// *** verif/smu_master_assertions.sv ***
`timescale 1ns/1ps
`include "smu_defines.svh"
module smu_master_assertions
	import smu_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int CHAN_N = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire smu_bus_req_t bus,
	input wire logic [31:0] bus_rdata,
	// event channels
	input wire logic [CHAN_N-1:0] chan_trig,
	input wire logic [CHAN_N-1:0] chan_pub,
	// buffer memory and serial pins
	input wire smu_mem_req_t mem,
	input wire logic [7:0] mem_rdata,
	input wire smu_pins_t pins,
	input wire logic din
);
	// ==========
	// shadow lengths, latched at an accepted start just as the engine must do
	logic en_q;
	logic fresh_q;
	logic [31:0] txl_q, rxl_q, ctx_q, crx_q, ntx_q, nrx_q, lwa_q;
	wire logic go = bus.wr && bus.addr == `SMU_OFS_TASK_BEGIN && bus.wdata[0] && en_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			en_q <= 1'b0;
			fresh_q <= 1'b1;
			{txl_q, rxl_q, ctx_q, crx_q, ntx_q, nrx_q, lwa_q} <= 224'h0;
		end else begin
			if (bus.wr && bus.addr == `SMU_OFS_ENABLE) en_q <= bus.wdata[3:0] == `SMU_ENABLE_ON;
			if (bus.wr && bus.addr == `SMU_OFS_TX_LEN) txl_q <= bus.wdata;
			if (bus.wr && bus.addr == `SMU_OFS_RX_LEN) rxl_q <= bus.wdata;
			if (go) begin
				ctx_q <= txl_q;
				crx_q <= rxl_q;
			end
			ntx_q <= go ? 32'h0 : ntx_q + 32'(mem.rd);
			nrx_q <= go ? 32'h0 : nrx_q + 32'(mem.wr);
			fresh_q <= go | (fresh_q & ~mem.wr);
			if (mem.wr) lwa_q <= mem.addr;
		end
	end
	// ==========
	// properties
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence fetch_s;
		mem.rd;
	endsequence
	sequence store_s;
		mem.wr && !fresh_q;
	endsequence
	rdata_quiet_a: assert property (!$past(bus.rd) |-> bus_rdata == 32'h0)
		else $error("read data outside its slot");
	idle_no_dma_a: assert property (!en_q |-> !(mem.rd || mem.wr))
		else $error("buffer access while disabled");
	quiet_pub_a: assert property (!en_q && !$past(en_q) |-> chan_pub == '0)
		else $error("event published while disabled");
	tx_fetch_bound_a: assert property (fetch_s |-> ntx_q < ctx_q)
		else $error("fetch beyond transmit length");
	rx_store_bound_a: assert property (mem.wr |-> nrx_q < crx_q)
		else $error("store beyond receive length");
	rx_addr_step_a: assert property (store_s |-> mem.addr == lwa_q + 32'h1)
		else $error("receive address not consecutive");
	fetch_gap_a: assert property (fetch_s |=> (!mem.rd) [*8])
		else $error("second fetch inside one byte time");
	pub_pulse_a: assert property (chan_pub != '0 |=> (chan_pub & $past(chan_pub)) == '0)
		else $error("published event longer than one cycle");
endmodule

bind smu_master smu_master_assertions #(.CNT_W(CNT_W), .CHAN_N(CHAN_N)) u_chk (.ref_clk(ref_clk), .rst(rst),
	.bus(bus), .bus_rdata(bus_rdata), .chan_trig(chan_trig), .chan_pub(chan_pub), .mem(mem),
	.mem_rdata(mem_rdata), .pins(pins), .din(din));

// *** verif/smu_slave_model.sv ***
`timescale 1ns/1ps
module smu_slave_model (
	// select from a spare output, and the mode in use
	input wire logic sel,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb,
	// serial lines
	input wire logic sck,
	input wire logic dout,
	output logic din
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rx = 8'h00;
	logic [7:0] nxt = 8'h00;
	logic [7:0] got [$];
	int nb = 0;
	// ==========
	// a released line shows the inverse so a stale bit cannot pass
	wire logic cur = lsb ? sh[0] : sh[7];
	assign din = sel ? cur : ~cur;
	// each select opens a frame with the first reply byte on the line
	always @(posedge sel) begin
		nxt = 8'h3C;
		sh = nxt;
		nb = 0;
	end
	// sample on leading edges in phase 0, on trailing edges in phase 1
	always @(sck) begin
		if (sel && ((sck != cpol) ^ cpha)) begin
			rx = lsb ? {dout, rx[7:1]} : {rx[6:0], dout};
			nb++;
			if (nb % 8 == 0) got.push_back(rx);
		end else if (sel && nb % 8 == 0 && nb > 0) begin
			nxt = nxt + 8'h07;
			sh = nxt;
		end else if (sel && nb % 8 != 0) begin
			sh = lsb ? sh >> 1 : sh << 1;
		end
	end
endmodule

// *** verif/spi_master_dma_tb.sv ***
`timescale 1ns/1ps
`include "smu_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module spi_master_dma_tb
	import smu_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic sel = 1'b0;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic lsb = 1'b0;
	smu_bus_req_t bus = '0;
	logic [31:0] bus_rdata, rv;
	logic [15:0] chan_trig = 16'h0000;
	logic [15:0] chan_pub;
	smu_mem_req_t mem;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] ram [256];
	smu_pins_t pins;
	logic din;
	int n_errors = 0;
	int checks_done = 0;
	int n_pub = 0;
	int seed = 32'h3A8051A2;
	int tl_tab [4] = '{2, 3, 1, 2};
	int rl_tab [4] = '{2, 1, 3, 2};
	logic [11:0] evts [5] = '{`SMU_OFS_EVT_HALTED, `SMU_OFS_EVT_RX_DONE, `SMU_OFS_EVT_BOTH_DONE,
		`SMU_OFS_EVT_TX_DONE, `SMU_OFS_EVT_BEGUN};
	logic [11:0] ra [6] = '{`SMU_OFS_PSEL_CLOCK, `SMU_OFS_BIT_RATE, `SMU_OFS_ENABLE, `SMU_OFS_SUB_BEGIN,
		`SMU_OFS_TASK_BEGIN, 12'h7FC};
	logic [31:0] rr [6] = '{32'hFFFFFFFF, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};

	always #50 ref_clk = ~ref_clk;
	// byte memory behind the buffer port, answers one cycle after the request
	always @(posedge ref_clk) begin
		if (mem.rd) mem_rdata <= ram[mem.addr[7:0]];
		if (mem.wr) ram[mem.addr[7:0]] <= mem.wdata;
	end
	// published begun pulses on channel 5, one count per one-cycle pulse
	always @(posedge ref_clk) begin
		if (chan_pub[5]) n_pub++;
	end

	smu_master DUT (.ref_clk(ref_clk), .rst(rst), .bus(bus), .bus_rdata(bus_rdata), .chan_trig(chan_trig),
		.chan_pub(chan_pub), .mem(mem), .mem_rdata(mem_rdata), .pins(pins), .din(din));
	smu_slave_model SLV (.sel(sel), .cpol(cpol), .cpha(cpha), .lsb(lsb), .sck(pins.sck), .dout(pins.dout),
		.din(din));

	// ==========
	// register port tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus <= '0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge ref_clk) bus <= '0;
		#1 rv = bus_rdata;
	endtask
	// polling is bounded so a lost event ends as a mismatch, not a hang
	task automatic wait_evt(input logic [11:0] a);
		int k;
		for (k = 0; k < 400; k++) begin
			rd(a);
			if (rv[0] === 1'b1) break;
		end
		`CHK(rv[0], 1'b1)
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// reply byte the slave model puts on the line in frame position i
	function automatic logic [7:0] exp_reply(input int i);
		exp_reply = 8'(8'h3C + 7 * i);
	endfunction
	// byte on the data-out line: the buffer first, then the over-read character
	function automatic logic [7:0] exp_sent(input int i, input int tl, input logic [7:0] overread_char);
		exp_sent = (i < tl) ? ram[8'h10 + i] : overread_char;
	endfunction
	// ==========
	// one transfer; op 1 halts it through a channel, op 2 pauses and continues it
	task automatic xfer(input int tl, input int rl, input int op);
		logic [7:0] overread_char;
		int i;
		int rc;
		overread_char = 8'($random(seed));
		for (i = 0; i < 8; i++) begin
			ram[8'h10 + i] = 8'($random(seed));
			ram[8'h80 + i] = 8'hEE;
		end
		wr(`SMU_OFS_OVERREAD, {24'h0, overread_char});
		wr(`SMU_OFS_TX_PTR, 32'h10);
		wr(`SMU_OFS_TX_LEN, 32'(tl));
		wr(`SMU_OFS_RX_PTR, 32'h80);
		wr(`SMU_OFS_RX_LEN, 32'(rl));
		SLV.got.delete();
		sel <= 1'b1;
		wr(`SMU_OFS_TASK_BEGIN, 32'h1);
		wait_evt(`SMU_OFS_EVT_BEGUN);
		`CHK({pins.sck_oe, pins.dout_oe}, 2'b11)
		wr(`SMU_OFS_TX_PTR, 32'h40);
		wr(`SMU_OFS_RX_LEN, 32'h1);
		if (op == 1) begin
			repeat (150) @(posedge ref_clk);
			chan_trig <= 16'h0008;
			@(posedge ref_clk) chan_trig <= 16'h0000;
			wait_evt(`SMU_OFS_EVT_HALTED);
		end
		if (op == 2) begin
			wr(`SMU_OFS_TASK_PAUSE, 32'h1);
			repeat (100) @(posedge ref_clk);
			rd(`SMU_OFS_RX_COUNT);
			rc = int'(rv);
			repeat (200) @(posedge ref_clk);
			@(negedge ref_clk);
			`CHK(pins.sck, cpol)
			rd(`SMU_OFS_RX_COUNT);
			`CHK(rv, 32'(rc))
			wr(`SMU_OFS_TASK_CONT, 32'h1);
		end
		if (op != 1) wait_evt(`SMU_OFS_EVT_BOTH_DONE);
		sel <= 1'b0;
		rd(`SMU_OFS_EVT_TX_DONE);
		`CHK(rv[0], 1'b1)
		rd(`SMU_OFS_EVT_RX_DONE);
		`CHK(rv[0], 1'b1)
		rd(`SMU_OFS_RX_COUNT);
		rc = int'(rv);
		if (op == 1) `CHK(rv < 32'(rl), 1'b1)
		else `CHK(rv, 32'(rl))
		rd(`SMU_OFS_TX_COUNT);
		`CHK(rv, 32'(op == 1 ? rc : tl))
		`CHK(SLV.got.size(), op == 1 ? rc : (tl > rl ? tl : rl))
		for (i = 0; i < SLV.got.size(); i++)
			`CHK(SLV.got[i], exp_sent(i, tl, overread_char))
		for (i = 0; i <= rc; i++)
			`CHK(ram[8'h80 + i], i < rc ? exp_reply(i) : 8'hEE)
		for (i = 0; i < 5; i++)
			wr(evts[i], 32'h0);
		rd(`SMU_OFS_EVT_BOTH_DONE);
		`CHK(rv, 32'h0)
	endtask

	// ==========
	// main sequence
	initial begin
		int t;
		int p0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		wr(12'h7FC, 32'hFFFFFFFF);
		for (t = 0; t < 6; t++) begin
			rd(ra[t]);
			`CHK(rv, rr[t])
		end
		$display("test resets done");
		wr(`SMU_OFS_PSEL_CLOCK, 32'h0);
		wr(`SMU_OFS_PSEL_DOUT, 32'h1);
		wr(`SMU_OFS_PSEL_DIN, 32'h2);
		wr(`SMU_OFS_SUB_HALT, 32'h80000003);
		wr(`SMU_OFS_PUB_BEGUN, 32'h80000005);
		for (t = 0; t < 4; t++) begin
			wr(`SMU_OFS_ENABLE, 32'h0);
			cpol <= t[1];
			cpha <= t[0];
			lsb <= t[0] & t[1];
			// mode 3 also runs least significant bit first
			wr(`SMU_OFS_CONFIG, {29'h0, t[1], t[0], t[0] & t[1]});
			wr(`SMU_OFS_ENABLE, 32'h7);
			xfer(tl_tab[t], rl_tab[t], 0);
			$display("test mode %0d done", t);
		end
		xfer(4, 4, 1);
		$display("test halt done");
		xfer(4, 4, 2);
		$display("test pause done");
		// six starts so far, each published once
		p0 = n_pub;
		`CHK(p0, 6)
		// zero lengths finish at once, so the shortcut keeps restarting until cleared
		wr(`SMU_OFS_TX_LEN, 32'h0);
		wr(`SMU_OFS_RX_LEN, 32'h0);
		wr(`SMU_OFS_EVENT_TASK_SHORTCUTS, 32'h1);
		wr(`SMU_OFS_TASK_BEGIN, 32'h1);
		repeat (4) @(posedge ref_clk);
		wr(`SMU_OFS_EVENT_TASK_SHORTCUTS, 32'h0);
		repeat (4) @(posedge ref_clk);
		`CHK(n_pub > p0 + 1, 1'b1)
		wr(`SMU_OFS_EVT_BEGUN, 32'h0);
		$display("test shortcut done");
		wr(`SMU_OFS_ENABLE, 32'h0);
		wr(`SMU_OFS_TASK_BEGIN, 32'h1);
		repeat (20) @(posedge ref_clk);
		rd(`SMU_OFS_EVT_BEGUN);
		`CHK(rv, 32'h0)
		`CHK({pins.sck_oe, pins.dout_oe}, 2'b00)
		$display("test disabled done");
		give_verdict();
	end
	// watchdog: the whole run needs well under ten thousand cycles
	initial begin
		#1000000;
		n_errors++;
		give_verdict();
	end
endmodule
